/* src/spmp_pkg.sv */
package spmp_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] SPMP_OFF_CONTROL = 8'h00;
  localparam logic [7:0] SPMP_OFF_STATUS  = 8'h04;
  localparam logic [7:0] SPMP_OFF_DATA    = 8'h08;
  localparam logic [7:0] SPMP_OFF_PINDIR  = 8'h0C;

  // port_control_reg fields
  localparam int SPMP_CTL_IRQ_ENABLE   = 7;
  localparam int SPMP_CTL_PORT_ENABLE  = 6;
  localparam int SPMP_CTL_LSB_FIRST    = 5;
  localparam int SPMP_CTL_MASTER       = 4;
  localparam int SPMP_CTL_IDLE_LEVEL   = 3;
  localparam int SPMP_CTL_SAMPLE_PHASE = 2;
  localparam int SPMP_CTL_RATE_HI      = 1;
  localparam int SPMP_CTL_RATE_LO      = 0;

  // port_status_reg fields
  localparam int SPMP_STS_DONE         = 7;
  localparam int SPMP_STS_COLLISION    = 6;
  localparam int SPMP_STS_DOUBLE_RATE  = 0;

  // Pin direction register fields
  localparam int SPMP_DIR_MOSI_OUT     = 0;
  localparam int SPMP_DIR_MISO_OUT     = 1;
  localparam int SPMP_DIR_SCK_OUT      = 2;
  localparam int SPMP_DIR_SELECT_OUT   = 3;
  localparam int SPMP_DIR_SELECT_LEVEL = 4;

  // Reset values
  localparam logic [7:0] SPMP_CONTROL_RST = 8'h00;
  localparam logic [4:0] SPMP_PINDIR_RST  = 5'h00;
  localparam logic [7:0] SPMP_DATA_RST    = 8'h00;

  // System clock divisors for the master serial clock
  localparam int SPMP_DIV_4   = 4;
  localparam int SPMP_DIV_16  = 16;
  localparam int SPMP_DIV_64  = 64;
  localparam int SPMP_DIV_128 = 128;
  localparam int SPMP_DIV_2   = 2;
  localparam int SPMP_DIV_8   = 8;
  localparam int SPMP_DIV_32  = 32;

  localparam logic [3:0] SPMP_BYTE_LAST_BIT = 4'h7;
  localparam logic [4:0] SPMP_LAST_EDGE     = 5'h0F;

  typedef enum logic [0:0] {
    SPMP_IDLE = 1'b0,
    SPMP_RUN  = 1'b1
  } spmp_engine_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spmp_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spmp_apb_rsp_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic select_n;
  } spmp_pins_in_type;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic select_n;
    logic select_oe_n;
  } spmp_pins_out_type;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic              double_rate;
    logic              done;
    logic              collision;
    logic              arm_done;
    logic              arm_coll;
    logic [4:0]        pindir;
    logic [7:0]        tx;
    logic [7:0]        tx_hold;
    logic [7:0]        rx_sh;
    logic [7:0]        rx_buf;
    logic [3:0]        bits;
    spmp_engine_type   engine;
    logic [6:0]        half_cnt;
    logic [4:0]        edges;
    logic              sck_q;
    logic              sck_prev;
    spmp_apb_rsp_type  apb;
    spmp_pins_out_type pout;
    logic              irq;
  } spmp_state_type;

  localparam spmp_state_type SPMP_STATE_RST = '{
    pout: '{sck_oe_n: 1'b1, mosi_oe_n: 1'b1, miso_oe_n: 1'b1, select_oe_n: 1'b1,
            default: 1'b0},
    engine: SPMP_IDLE,
    default: '0
  };

endpackage

/* src/spmp_top.sv */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Behaviour
// [R01] Slave select is input in slave mode; low activates, data-out drives if configured.
// [R02] Slave select high resets slave bit counter and drops partly received byte.
// [R03] Master with select configured as output: select is a plain output pin.
// [R04] Master with select input pulled low: drop to slave, set done flag.
// [R05] Software must re-set master select after a select conflict.
// [R06] Control bit 7 with done flag and global enable raises the interrupt.
// [R07] Control bit 6 enables the port; nothing happens without it.
// [R08] Control bit 5 one sends least significant bit first.
// [R09] Control bit 4 selects master; hardware clears it on select conflict.
// [R10] Control bit 3 sets serial clock idle level.
// [R11] Control bit 2 chooses sampling on leading or trailing edge.
// [R12] Rate bits with double rate divide the system clock 4..128 or 2..64.
// [R13] Rate bits are ignored in slave mode; slave follows external clock.
// [R14] Status bit 7 sets on byte completion or master select conflict.
// [R15] Done clears on vector taken, or status read with flag then data access.
// [R16] Status bit 6 sets when data is written during a transfer.
// [R17] Status read with collision set, then data access, clears both flags.
// [R18] Status bits 5 to 1 read as zero.
// [R19] Status bit 0 doubles master serial clock rate.
// [R20] External master keeps serial clock at a quarter system clock or slower.
// [R21] Data write starts a transfer; data read returns the receive buffer.
// [R22] Shift and latch on opposite edges; polarity/phase give modes 0 to 3.
// [R23] Master shifts eight bits, stops, sets done, keeps received byte.
// [R24] Receive buffer is overwritten if not read before next byte ends.
// [R25] External serial clock phases must exceed two system clock cycles.
// [R26] After reset all control and status bits are zero.
module spmp_top (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire spmp_pkg::spmp_apb_req_type apb_i,
  output wire spmp_pkg::spmp_apb_rsp_type apb_o,
  input  wire spmp_pkg::spmp_pins_in_type pins_i,
  output wire spmp_pkg::spmp_pins_out_type pins_o,
  input  wire logic                       global_irq_en_i,
  input  wire logic                       irq_ack_i,
  output wire logic                       irq_o
);
  import spmp_pkg::*;

  spmp_state_type s;
  spmp_state_type next_s;

  function automatic logic [6:0] half_period(input logic [1:0] rate, input logic dbl);
    int div;
    div = SPMP_DIV_4;
    case ({dbl, rate})
      3'b000:  div = SPMP_DIV_4;
      3'b001:  div = SPMP_DIV_16;
      3'b010:  div = SPMP_DIV_64;
      3'b011:  div = SPMP_DIV_128;
      3'b100:  div = SPMP_DIV_2;
      3'b101:  div = SPMP_DIV_8;
      3'b110:  div = SPMP_DIV_32;
      3'b111:  div = SPMP_DIV_64;
      default: div = SPMP_DIV_4;
    endcase
    half_period = 7'(div / 2);
  endfunction

  function automatic logic out_bit(input logic [7:0] data, input logic lsb_first);
    out_bit = lsb_first ? data[0] : data[7];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == SPMP_OFF_CONTROL) || (addr == SPMP_OFF_STATUS) ||
             (addr == SPMP_OFF_DATA) || (addr == SPMP_OFF_PINDIR);
  endfunction

  always_comb begin
    logic        en;
    logic        master;
    logic        lsb;
    logic        clock_idle_level;
    logic        clock_sample_phase;
    logic        setup_phase;
    logic        commit;
    logic        busy;
    logic        lead;
    logic        trail;
    logic        sample_ev;
    logic        setup_ev;
    logic        finish;
    logic        in_bit;
    logic        set_done;
    logic        set_coll;
    logic        clr_done;
    logic        clr_coll;
    logic [7:0]  new_rx;
    logic [31:0] rdata;
    next_s      = s;
    en          = s.ctrl[SPMP_CTL_PORT_ENABLE];
    master      = s.ctrl[SPMP_CTL_MASTER];
    lsb         = s.ctrl[SPMP_CTL_LSB_FIRST];
    clock_idle_level        = s.ctrl[SPMP_CTL_IDLE_LEVEL];
    clock_sample_phase        = s.ctrl[SPMP_CTL_SAMPLE_PHASE];
    setup_phase = apb_i.psel && !apb_i.penable;
    commit      = apb_i.psel && apb_i.penable && s.apb.pready;
    busy        = (s.engine == SPMP_RUN) || (!master && s.bits != 4'h0);
    lead        = 1'b0;
    trail       = 1'b0;
    sample_ev   = 1'b0;
    setup_ev    = 1'b0;
    finish      = 1'b0;
    set_done    = 1'b0;
    set_coll    = 1'b0;
    clr_done    = 1'b0;
    clr_coll    = 1'b0;
    new_rx      = s.rx_sh;
    in_bit      = master ? pins_i.miso : pins_i.mosi;
    rdata       = 32'h0000_0000;

    // Read data is captured in the setup cycle so pready can come from a flop
    case (apb_i.paddr)
      SPMP_OFF_CONTROL: rdata[7:0] = s.ctrl;
      SPMP_OFF_STATUS: begin
        rdata[SPMP_STS_DONE]        = s.done; // R18
        rdata[SPMP_STS_COLLISION]   = s.collision;
        rdata[SPMP_STS_DOUBLE_RATE] = s.double_rate;
      end
      SPMP_OFF_DATA:    rdata[7:0] = s.rx_buf; // R21
      SPMP_OFF_PINDIR:  rdata[4:0] = s.pindir;
      default:          rdata = 32'h0000_0000;
    endcase
    next_s.apb.pready = setup_phase;
    if (setup_phase) begin
      next_s.apb.prdata  = rdata;
      next_s.apb.pslverr = !mapped(apb_i.paddr);
    end

    if (commit && !s.apb.pslverr) begin
      if (apb_i.pwrite) begin
        case (apb_i.paddr)
          SPMP_OFF_CONTROL: next_s.ctrl = apb_i.pwdata[7:0]; // R07 R09
          SPMP_OFF_STATUS:  next_s.double_rate = apb_i.pwdata[SPMP_STS_DOUBLE_RATE];
          SPMP_OFF_PINDIR:  next_s.pindir = apb_i.pwdata[4:0];
          SPMP_OFF_DATA: begin
            if (busy) begin
              set_coll = 1'b1; // R16
            end else begin
              next_s.tx      = apb_i.pwdata[7:0]; // R21
              next_s.tx_hold = apb_i.pwdata[7:0];
              if (en && master) begin
                next_s.engine   = SPMP_RUN; // R23
                next_s.half_cnt = half_period(s.ctrl[1:0], s.double_rate);
                next_s.edges    = 5'h00;
                next_s.bits     = 4'h0;
                next_s.sck_q    = clock_idle_level;
              end
            end
          end
          default: next_s.ctrl = s.ctrl;
        endcase
      end else if (apb_i.paddr == SPMP_OFF_STATUS) begin
        // The value the master actually saw arms the clear
        if (s.apb.prdata[SPMP_STS_DONE]) begin
          next_s.arm_done = 1'b1; // R15
        end
        if (s.apb.prdata[SPMP_STS_COLLISION]) begin
          next_s.arm_coll = 1'b1; // R17
        end
      end
      if (apb_i.paddr == SPMP_OFF_DATA) begin
        clr_done        = s.arm_done || s.arm_coll; // R15 R17
        clr_coll        = s.arm_coll; // R17
        next_s.arm_done = 1'b0;
        next_s.arm_coll = 1'b0;
      end
    end

    if (!en) begin
      next_s.engine = SPMP_IDLE; // R07
      next_s.bits   = 4'h0;
      next_s.sck_q  = clock_idle_level;
    end else if (master) begin
      if (!s.pindir[SPMP_DIR_SELECT_OUT] && !pins_i.select_n) begin
        // Another master owns the bus: back off before driving into it
        next_s.ctrl[SPMP_CTL_MASTER] = 1'b0; // R04 R09
        next_s.engine                = SPMP_IDLE;
        next_s.bits                  = 4'h0;
        next_s.sck_q                 = clock_idle_level;
        set_done                     = 1'b1; // R14
      end else if (s.engine == SPMP_RUN) begin
        if (s.half_cnt <= 7'h01) begin
          next_s.sck_q    = !s.sck_q; // R10
          next_s.edges    = s.edges + 5'h01;
          next_s.half_cnt = half_period(s.ctrl[1:0], s.double_rate); // R12 R19
          lead            = !s.edges[0];
          trail           = s.edges[0];
          if (s.edges == SPMP_LAST_EDGE) begin
            finish        = 1'b1; // R23
            next_s.engine = SPMP_IDLE;
          end
        end else begin
          next_s.half_cnt = s.half_cnt - 7'h01;
        end
      end else if (next_s.engine == SPMP_IDLE) begin
        next_s.sck_q = clock_idle_level; // R10
      end
    end else begin
      if (pins_i.select_n) begin
        next_s.bits  = 4'h0; // R02
        next_s.rx_sh = 8'h00;
        next_s.tx    = s.tx_hold;
      end else if (pins_i.sck != s.sck_prev) begin
        // Edges seen at system clock rate; slower external clock assumed
        lead  = (pins_i.sck != clock_idle_level); // R13 R20 R25 R01
        trail = !lead;
      end
    end
    next_s.sck_prev = pins_i.sck;

    sample_ev = clock_sample_phase ? trail : lead; // R11 R22
    setup_ev  = clock_sample_phase ? lead : trail; // R22
    if (sample_ev) begin
      new_rx        = lsb ? {in_bit, s.rx_sh[7:1]} : {s.rx_sh[6:0], in_bit}; // R08
      next_s.rx_sh  = new_rx;
      next_s.bits   = s.bits + 4'h1;
      if (!master && s.bits == SPMP_BYTE_LAST_BIT) begin
        next_s.rx_buf = new_rx; // R24
        next_s.bits   = 4'h0;
        set_done      = 1'b1; // R14
      end
    end
    // No shift before the first sample, so phase 1 keeps the first data bit on the line
    if (setup_ev && s.bits != 4'h0) begin
      next_s.tx = lsb ? {1'b0, s.tx[7:1]} : {s.tx[6:0], 1'b0}; // R08 R22
    end
    if (finish) begin
      next_s.rx_buf = new_rx; // R23 R24
      next_s.bits   = 4'h0;
      set_done      = 1'b1; // R14
    end

    // Hardware set wins over any clear in the same cycle
    next_s.done      = set_done || (s.done && !clr_done && !irq_ack_i); // R14 R15
    next_s.collision = set_coll || (s.collision && !clr_coll); // R16 R17

    next_s.irq = next_s.ctrl[SPMP_CTL_IRQ_ENABLE] && next_s.done && global_irq_en_i; // R06

    next_s.pout.sck         = next_s.sck_q;
    next_s.pout.sck_oe_n    = !(next_s.ctrl[SPMP_CTL_PORT_ENABLE] &&
                                next_s.ctrl[SPMP_CTL_MASTER] &&
                                next_s.pindir[SPMP_DIR_SCK_OUT]); // R04
    next_s.pout.mosi        = out_bit(next_s.tx, next_s.ctrl[SPMP_CTL_LSB_FIRST]);
    next_s.pout.mosi_oe_n   = !(next_s.ctrl[SPMP_CTL_PORT_ENABLE] &&
                                next_s.ctrl[SPMP_CTL_MASTER] &&
                                next_s.pindir[SPMP_DIR_MOSI_OUT]); // R04
    next_s.pout.miso        = out_bit(next_s.tx, next_s.ctrl[SPMP_CTL_LSB_FIRST]);
    next_s.pout.miso_oe_n   = !(next_s.ctrl[SPMP_CTL_PORT_ENABLE] &&
                                !next_s.ctrl[SPMP_CTL_MASTER] && !pins_i.select_n &&
                                next_s.pindir[SPMP_DIR_MISO_OUT]); // R01
    next_s.pout.select_n    = next_s.pindir[SPMP_DIR_SELECT_LEVEL]; // R03
    next_s.pout.select_oe_n = !(next_s.ctrl[SPMP_CTL_PORT_ENABLE] &&
                                next_s.ctrl[SPMP_CTL_MASTER] &&
                                next_s.pindir[SPMP_DIR_SELECT_OUT]); // R03 R01
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= SPMP_STATE_RST; // R26
    end else begin
      s <= next_s;
    end
  end

  assign apb_o  = s.apb;
  assign pins_o = s.pout;
  assign irq_o  = s.irq;

endmodule

/* tb/spmp_peer.sv */
`timescale 1ns/10ps
module spmp_peer (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic       clock_idle_level_i,
  input  wire logic       clock_sample_phase_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output wire logic       miso_o,
  output logic      [7:0] rx_o
);
  logic [7:0] sh;
  logic [3:0] n;
  logic       last = 1'b0;
  wire logic  cur = lsb_i ? sh[0] : sh[7];
  // Released line shows the inverse of its last bit so a stale value never passes
  assign miso_o = sel_n_i ? ~last : cur;
  always @(posedge sel_n_i) last <= cur;
  always @(negedge sel_n_i) begin
    sh <= tx_i;
    n  <= 4'h0;
  end
  // Clocked by the serial clock itself, as a real peripheral is
  always @(sck_i) begin
    if (!sel_n_i) begin
      if ((sck_i != clock_idle_level_i) != clock_sample_phase_i) begin
        rx_o <= lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
        n    <= n + 4'h1;
      end else if (n != 4'h0) begin
        sh <= lsb_i ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
      end
    end
  end
endmodule

/* tb/spmp_props.sv */
`timescale 1ns/10ps
module spmp_props (
  input wire logic                        clk_i,
  input wire logic                        resetn_i,
  input wire spmp_pkg::spmp_apb_req_type  apb_i,
  input wire spmp_pkg::spmp_apb_rsp_type  apb_o,
  input wire spmp_pkg::spmp_pins_in_type  pins_i,
  input wire spmp_pkg::spmp_pins_out_type pins_o,
  input wire logic                        global_irq_en_i,
  input wire logic                        irq_ack_i,
  input wire logic                        irq_o
);
  import spmp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_PREADY_NEXT: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
    else $error("pready missing after setup");
  AST_PREADY_PULSE: assert property (apb_o.pready |=> !apb_o.pready)
    else $error("pready longer than one cycle");
  AST_RSVD_ZERO: assert property (apb_o.pready && !apb_i.pwrite
    && apb_i.paddr == SPMP_OFF_STATUS |-> apb_o.prdata[31:8] == 0 && apb_o.prdata[5:1] == 0)
    else $error("reserved status bits not zero");
  AST_UNMAPPED: assert property (apb_o.pready && apb_i.paddr > SPMP_OFF_PINDIR
    |-> apb_o.pslverr && apb_o.prdata == 0)
    else $error("unmapped access not refused");
  AST_RESET_IDLE: assert property ($rose(resetn_i) |-> !apb_o.pready && !irq_o
    && pins_o.sck_oe_n && pins_o.mosi_oe_n && pins_o.miso_oe_n)
    else $error("outputs not idle after reset");
  AST_IRQ_GLOBAL: assert property (!global_irq_en_i |=> !irq_o)
    else $error("interrupt without global enable");
  AST_MISO_IDLE: assert property (pins_i.select_n [*3] |-> pins_o.miso_oe_n)
    else $error("data out driven while deselected");
  AST_CONFLICT_DROP: assert property (!pins_o.sck_oe_n && !pins_i.select_n
    && pins_o.select_oe_n |-> ##[1:4] pins_o.sck_oe_n)
    else $error("master kept clock on select conflict");
  AST_ACK_CLEARS: assert property (irq_ack_i |-> ##2 !irq_o)
    else $error("interrupt stays after vector taken");
endmodule
bind spmp_top spmp_props u_spmp_props (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb_i),
  .apb_o(apb_o), .pins_i(pins_i), .pins_o(pins_o), .global_irq_en_i(global_irq_en_i),
  .irq_ack_i(irq_ack_i), .irq_o(irq_o));

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import spmp_pkg::*;
  logic              clk_i    = 1'b0;
  logic              resetn_i = 1'b0;
  spmp_apb_req_type  req      = '0;
  spmp_apb_rsp_type  rsp;
  spmp_pins_out_type po;
  spmp_pins_in_type  pi;
  logic              gie      = 1'b0;
  logic              ack      = 1'b0;
  logic              tb_sel_n = 1'b1;
  logic              tb_sck   = 1'b0;
  logic              tb_mosi  = 1'b0;
  logic              clock_idle_level     = 1'b0;
  logic              clock_sample_phase     = 1'b0;
  logic              lsb      = 1'b0;
  logic              irq, pmiso, sck_q;
  logic [7:0]        ptx      = 8'h00;
  logic [7:0]        prx;
  logic [7:0]        offs [4] = '{SPMP_OFF_CONTROL, SPMP_OFF_STATUS, SPMP_OFF_DATA, 8'h10};
  int                divs [8] = '{SPMP_DIV_4, SPMP_DIV_16, SPMP_DIV_64, SPMP_DIV_128,
                                  SPMP_DIV_2, SPMP_DIV_8, SPMP_DIV_32, SPMP_DIV_64};
  int                mismatches, n_compared, cyc, hcnt, half;
  always #25 clk_i = ~clk_i;
  assign pi = '{sck: po.sck_oe_n ? tb_sck : po.sck, mosi: tb_mosi, miso: pmiso,
                select_n: po.select_oe_n ? tb_sel_n : po.select_n};
  spmp_top u_spmp_top (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(req), .apb_o(rsp),
    .pins_i(pi), .pins_o(po), .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq));
  spmp_peer u_spmp_peer (.sck_i(po.sck), .mosi_i(po.mosi), .sel_n_i(pi.select_n),
    .clock_idle_level_i(clock_idle_level), .clock_sample_phase_i(clock_sample_phase), .lsb_i(lsb), .tx_i(ptx), .miso_o(pmiso), .rx_o(prx));
  // Half period of the serial clock, in system clocks, between its last two edges
  always @(posedge clk_i) begin
    cyc   <= cyc + 1;
    sck_q <= po.sck;
    hcnt  <= (po.sck !== sck_q) ? 1 : hcnt + 1;
    if (po.sck !== sck_q) half <= hcnt;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end
  function automatic int half_of(logic d, logic [1:0] r);
    return divs[{d, r}] / 2;
  endfunction
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd);
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk_i);
    req.penable <= 1'b1;
    // No wait limit here: a hang is caught by the cycle ceiling
    do begin
      @(posedge clk_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] x;
    apb(1'b0, a, 8'h00, x);
    chk(x, {24'h0, e});
  endtask
  task automatic wait_done(output logic [31:0] x);
    do begin
      apb(1'b0, SPMP_OFF_STATUS, 8'h00, x);
    end while (x[7] !== 1'b1);
  endtask
  // External master for slave mode; each clock phase lasts 4 system clocks
  task automatic sxfer(input int nb, input logic [7:0] mo, output logic [7:0] mi);
    mi = 8'h00;
    for (int i = 0; i < nb; i++) begin
      if (!clock_sample_phase)
        tb_mosi <= lsb ? mo[i] : mo[7 - i];
      repeat (4) @(posedge clk_i);
      if (clock_sample_phase)
        tb_mosi <= lsb ? mo[i] : mo[7 - i];
      if (!clock_sample_phase)
        mi = lsb ? {po.miso, mi[7:1]} : {mi[6:0], po.miso};
      chk(po.miso_oe_n, 1'b0);
      tb_sck <= ~clock_idle_level;
      repeat (4) @(posedge clk_i);
      if (clock_sample_phase)
        mi = lsb ? {po.miso, mi[7:1]} : {mi[6:0], po.miso};
      tb_sck <= clock_idle_level;
    end
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    logic [31:0] x;
    logic [7:0]  tx;
    logic [2:0]  md;
    logic [1:0]  rate;
    logic        dr;
    logic [7:0]  stx, srx, mi;
    x = $urandom(32'h9A7397EE);
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (offs[i]) rdc(offs[i], 8'h00);
    wr(SPMP_OFF_STATUS, 8'hFF);
    rdc(SPMP_OFF_STATUS, 8'h01);
    wr(SPMP_OFF_CONTROL, 8'h10);
    wr(SPMP_OFF_DATA, 8'hA5);
    repeat (40) @(posedge clk_i);
    rdc(SPMP_OFF_STATUS, 8'h01);
    for (int m = 0; m < 8; m++) begin
      wr(SPMP_OFF_PINDIR, 8'h1D);
      md = 3'(m * 5);
      {dr, rate} = 3'(m);
      tx = 8'($urandom);
      {lsb, clock_idle_level, clock_sample_phase} <= md;
      ptx <= 8'($urandom);
      wr(SPMP_OFF_STATUS, {7'h00, dr});
      wr(SPMP_OFF_CONTROL, {2'b01, md[2], 1'b1, md[1:0], rate});
      wr(SPMP_OFF_PINDIR, 8'h0D);
      wr(SPMP_OFF_DATA, tx);
      wait_done(x);
      chk(prx, tx);
      chk(half, half_of(dr, rate));
      chk(po.sck, md[1]);
      rdc(SPMP_OFF_DATA, ptx);
      rdc(SPMP_OFF_STATUS, {7'h00, dr});
    end
    wr(SPMP_OFF_DATA, tx);
    wr(SPMP_OFF_DATA, ~tx);
    wait_done(x);
    chk(x, {24'h0, 8'hC0 | {7'h00, dr}});
    chk(prx, tx);
    apb(1'b0, SPMP_OFF_DATA, 8'h00, x);
    rdc(SPMP_OFF_STATUS, {7'h00, dr});
    wr(SPMP_OFF_PINDIR, 8'h05);
    wr(SPMP_OFF_CONTROL, 8'hD0);
    gie <= 1'b1;
    tb_sel_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(irq, 1'b1);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b0);
    rdc(SPMP_OFF_CONTROL, 8'hC0);
    tb_sel_n <= 1'b1;
    wr(SPMP_OFF_CONTROL, 8'h50);
    rdc(SPMP_OFF_CONTROL, 8'h50);
    wr(SPMP_OFF_PINDIR, 8'h02);
    for (int m = 0; m < 4; m++) begin
      md = 3'(m * 3);
      stx = 8'($urandom);
      srx = 8'($urandom);
      {lsb, clock_idle_level, clock_sample_phase} <= md;
      tb_sck <= md[1];
      wr(SPMP_OFF_CONTROL, {2'b01, md[2], 1'b0, md[1:0], 2'b11});
      wr(SPMP_OFF_DATA, stx);
      tb_sel_n <= 1'b0;
      sxfer(3, ~srx, mi);
      tb_sel_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(po.miso_oe_n, 1'b1);
      tb_sel_n <= 1'b0;
      sxfer(8, srx, mi);
      chk(mi, stx);
      wr(SPMP_OFF_DATA, ~stx);
      sxfer(8, ~srx, mi);
      chk(mi, {24'h0, ~stx});
      rdc(SPMP_OFF_STATUS, {1'b1, 6'h00, dr});
      rdc(SPMP_OFF_DATA, ~srx);
      rdc(SPMP_OFF_STATUS, {7'h00, dr});
      tb_sel_n <= 1'b1;
    end
    end_sim();
  end
endmodule
